// ### verilog/ldc_top.sv
// Display drive control: AXI4-Lite register slave, scan rate generator and
// the bias, backplane and segment line drive of a segmented glass panel.
// Assumes an AXI4-Lite master on I_SYS_CLK and a free-running converter
// clock pin; the glass and the analog bias switches sit outside.
`default_nettype none
`include "ldc_cfg.svh"

module ldc_top #(
  parameter int NSEG     = 8,
  parameter int PRESCALE = `LDC_PRESCALE
) (
  // Clock and reset
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RESET_N,
  // Converter clock pin
  input  wire logic                I_CONV_CLK,
  // AXI4-Lite write address and data
  input  wire logic                I_AWVALID,
  output logic                     O_AWREADY,
  input  wire logic [15:0]         I_AWADDR,
  input  wire logic                I_WVALID,
  output logic                     O_WREADY,
  input  wire logic [31:0]         I_WDATA,
  input  wire logic [3:0]          I_WSTRB,
  // AXI4-Lite write response
  output logic                     O_BVALID,
  input  wire logic                I_BREADY,
  output ldc_pkg::ldc_resp_t       O_BRESP,
  // AXI4-Lite read address and data
  input  wire logic                I_ARVALID,
  output logic                     O_ARREADY,
  input  wire logic [15:0]         I_ARADDR,
  output logic                     O_RVALID,
  input  wire logic                I_RREADY,
  output logic [31:0]              O_RDATA,
  output ldc_pkg::ldc_resp_t       O_RRESP,
  // Panel drive
  output logic                     O_BIAS_LEVEL_OUT_LOW,
  output logic                     O_BIAS_LEVEL_OUT_MID,
  output logic                     O_BIAS_LEVEL_OUT_HIGH,
  output logic                     O_BACKPLANE,
  output logic [NSEG-1:0]          O_SEG
);

  import ldc_pkg::*;

  logic [`LDC_CTRL_W-1:0] ctrl;
  logic [NSEG-1:0]        segs;
  logic                   aw_have;
  logic                   w_have;
  logic [13:0]            aw_idx;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   do_write;
  logic [13:0]            ar_idx;
  logic                   base_tick;
  ldc_sel_t               active_sel;
  logic [8:0]             scan_cnt;
  logic [8:0]             scan_lim;
  logic                   scan_wrap;
  logic                   phase;
  logic                   next_en;
  logic [31:0]            next_rdata;
  ldc_resp_t              next_rresp;

  // Converter clock to base frequency pulse
  ldc_prescale #(
    .PRESCALE (PRESCALE)
  ) u_prescale (
    .i_clk      (I_SYS_CLK),
    .i_reset_n  (I_RESET_N),
    .i_conv_clk (I_CONV_CLK),
    .o_tick     (base_tick)
  );

  // Write address and data are accepted independently; each is held until
  // both are present, so the master may offer them in either order.
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_idx  <= 14'h0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_have <= 1'b1;
        aw_idx  <= I_AWADDR[15:2];
      end else if (do_write) begin
        aw_have <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_have <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end else if (do_write) begin
        w_have <= 1'b0;
      end
    end
  end

  // A write completes once both halves are held and no response is pending
  assign do_write = aw_have && w_have && !O_BVALID;

  // Ready is withdrawn while a half is held, so one write at a time
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
    end else begin
      O_AWREADY <= !(aw_have || (I_AWVALID && O_AWREADY)) || do_write;
      O_WREADY  <= !(w_have || (I_WVALID && O_WREADY)) || do_write;
    end
  end

  // Write response; unmapped indices answer SLVERR and change nothing
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= LDC_RESP_OKAY;
    end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= (aw_idx == `LDC_IDX_CTRL || aw_idx == `LDC_IDX_SEGS) ?
                  LDC_RESP_OKAY : LDC_RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // control fields stored
  // Only byte lane 0 carries bits; the upper lanes are not stored.
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl <= `LDC_CTRL_RST;
    end else if (do_write && aw_idx == `LDC_IDX_CTRL && w_strb[0]) begin
      ctrl <= w_data[`LDC_CTRL_W-1:0];
    end
  end

  // Segment pattern register, one bit per segment line
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      segs <= NSEG'(`LDC_SEGS_RST);
    end else if (do_write && aw_idx == `LDC_IDX_SEGS) begin
      for (int b = 0; b < NSEG; b++) begin
        if (w_strb[b/8]) begin
          segs[b] <= w_data[b];
        end
      end
    end
  end

  always_comb begin
    ar_idx     = I_ARADDR[15:2];
    next_rdata = 32'h0000_0000;
    next_rresp = LDC_RESP_OKAY;
    unique case (ar_idx)
      `LDC_IDX_CTRL: begin
        next_rdata[`LDC_CTRL_W-1:0] = ctrl;
      end
      `LDC_IDX_SEGS: begin
        next_rdata[NSEG-1:0] = segs;
      end
      `LDC_IDX_STAT: begin
        next_rdata[3]   = phase;
        next_rdata[2]   = O_BIAS_LEVEL_OUT_HIGH;
        next_rdata[1:0] = active_sel;
      end
      default: begin
        next_rresp = LDC_RESP_SLVERR;
      end
    endcase
  end

  // Read channel: one read at a time, data held until taken
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= LDC_RESP_OKAY;
    end else begin
      O_ARREADY <= 1'b0;
      if (I_ARVALID && !O_ARREADY && !O_RVALID) begin
        O_ARREADY <= 1'b1;
        O_RVALID  <= 1'b1;
        O_RDATA   <= next_rdata;
        O_RRESP   <= next_rresp;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (active_sel)
      LDC_SEL_DIV512: scan_lim = `LDC_LIM_SEL0;
      LDC_SEL_DIV256: scan_lim = `LDC_LIM_SEL1;
      LDC_SEL_DIV128: scan_lim = `LDC_LIM_SEL2;
      LDC_SEL_DIV64:  scan_lim = `LDC_LIM_SEL3;
    endcase
  end

  assign scan_wrap = base_tick && (scan_cnt == scan_lim);

  // boundary-aligned rate change
  // The selector is only sampled at a wrap, so a rate change never cuts a
  // line period short and never produces a runt pulse on the glass.
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      scan_cnt   <= 9'h000;
      active_sel <= ldc_sel_t'(2'(`LDC_CTRL_RST >> `LDC_SEL_LSB));
      phase      <= 1'b0;
    end else if (scan_wrap) begin
      scan_cnt   <= 9'h000;
      active_sel <= ldc_sel_t'(ctrl[`LDC_SEL_MSB:`LDC_SEL_LSB]);
      phase      <= !phase;
    end else if (base_tick) begin
      scan_cnt <= scan_cnt + 9'h001;
    end
  end

  // immediate switch-off
  // The new enable is used in the same edge as the register write, so the
  // lines drop together with the stored bit, not a scan period later.
  always_comb begin
    next_en = ctrl[`LDC_EN_BIT];
    if (do_write && aw_idx == `LDC_IDX_CTRL && w_strb[0]) begin
      next_en = w_data[`LDC_EN_BIT];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_BIAS_LEVEL_OUT_LOW  <= 1'b0;
      O_BIAS_LEVEL_OUT_MID  <= 1'b0;
      O_BIAS_LEVEL_OUT_HIGH <= 1'b0;
      O_BACKPLANE           <= 1'b0;
      O_SEG                 <= '0;
    end else if (next_en) begin
      O_BIAS_LEVEL_OUT_LOW  <= 1'b1;
      O_BIAS_LEVEL_OUT_MID  <= 1'b1;
      O_BIAS_LEVEL_OUT_HIGH <= 1'b1;
      O_BACKPLANE           <= phase;
      // Lit segments run opposite to the backplane; no net DC on the glass
      O_SEG                 <= segs ^ {NSEG{phase}};
    end else begin
      O_BIAS_LEVEL_OUT_LOW  <= 1'b0;
      O_BIAS_LEVEL_OUT_MID  <= 1'b0;
      O_BIAS_LEVEL_OUT_HIGH <= 1'b0;
      O_BACKPLANE           <= 1'b0;
      O_SEG                 <= '0;
    end
  end

endmodule // ldc_top

`default_nettype wire

// ### inc/ldc_cfg.svh
// Register map, field positions, reset values and divider counts of the
// display drive control block. Included by the package and the design files.
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define LDC_IDX_CTRL      14'h2021
`define LDC_IDX_SEGS      14'h2022
`define LDC_IDX_STAT      14'h2023

// Control register field positions
`define LDC_EN_BIT        5
`define LDC_SEL_LSB       0
`define LDC_SEL_MSB       1
`define LDC_CTRL_W        8

// Reset values: scan rate selector 01, display output off
`define LDC_CTRL_RST      8'h01
`define LDC_SEGS_RST      8'h00

// Converter clock to scan base frequency
`define LDC_PRESCALE      128
`define LDC_BASE_HZ       38400

// Base-frequency ticks per line change for each selector code, minus one
`define LDC_LIM_SEL0      9'h1FF
`define LDC_LIM_SEL1      9'h0FF
`define LDC_LIM_SEL2      9'h07F
`define LDC_LIM_SEL3      9'h03F

// Bus responses
`define LDC_RESP_OKAY     2'b00
`define LDC_RESP_SLVERR   2'b10

`endif

// ### inc/ldc_pkg.sv
// Types shared by the display drive control design.
// Assumes ldc_cfg.svh is on the include path.
`default_nettype none
`include "ldc_cfg.svh"

package ldc_pkg;

  // Scan rate selector codes: base frequency divided by 2^9 .. 2^6
  typedef enum logic [1:0] {
    LDC_SEL_DIV512 = 2'b00,
    LDC_SEL_DIV256 = 2'b01,
    LDC_SEL_DIV128 = 2'b10,
    LDC_SEL_DIV64  = 2'b11
  } ldc_sel_t;

  // AXI4-Lite response codes used by the slave
  typedef enum logic [1:0] {
    LDC_RESP_OKAY   = `LDC_RESP_OKAY,
    LDC_RESP_SLVERR = `LDC_RESP_SLVERR
  } ldc_resp_t;

endpackage

`default_nettype wire

// ### verilog/ldc_prescale.sv
// Prescaler: synchronises the converter clock pin and emits one system
// clock pulse every PRESCALE rising edges of it.
// Assumes the converter clock is well below half the system clock rate.
`default_nettype none
`include "ldc_cfg.svh"

module ldc_prescale #(
  parameter int PRESCALE = `LDC_PRESCALE
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Converter clock pin, asynchronous to i_clk
  input  wire logic i_conv_clk,
  // One-cycle pulse at the scan base frequency
  output logic      o_tick
);

  localparam int CW = $clog2(PRESCALE);

  logic          sync_a;
  logic          sync_b;
  logic          sync_c;
  logic [CW-1:0] count;

  // Two-stage synchroniser plus a history bit for edge detection
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= i_conv_clk;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (sync_b && !sync_c) begin
        if (count == CW'(PRESCALE - 1)) begin
          count  <= '0;
          o_tick <= 1'b1;
        end else begin
          count <= count + CW'(1);
        end
      end
    end
  end

endmodule // ldc_prescale

`default_nettype wire

// ### sim/ldc_glass_model.sv
// Glass panel stand-in: tells when the panel is dark and times backplane changes.
// Assumes one backplane line and eight segment lines.
`default_nettype none
module ldc_glass_model (
  // Drive from the block
  input  wire logic       i_bias_low,
  input  wire logic       i_bias_mid,
  input  wire logic       i_bias_high,
  input  wire logic       i_backplane,
  input  wire logic [7:0] i_seg,
  // Observations
  output logic            o_dark,
  output var logic [31:0] o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime last = 0.0;
  // Dark: no bias and every line at ground
  assign o_dark = !(i_bias_low | i_bias_mid | i_bias_high | i_backplane | (|i_seg));
  // Glass only sees level changes, so time the backplane
  always @(i_backplane) begin
    o_period = int'($realtime - last);
    last = $realtime;
  end
endmodule // ldc_glass_model
`default_nettype wire

// ### sim/ldc_top_checker.sv
// Port checker of the display drive control block, bound to its top.
// Assumes CONV_CYC system cycles per converter clock period.
`default_nettype none
module ldc_top_checker #(
  parameter int NSEG     = 8,
  parameter int PRESCALE = 128,
  parameter int CONV_CYC = 2
) (
  // Clock and reset
  input wire logic            I_SYS_CLK,
  input wire logic            I_RESET_N,
  // Bus handshakes and read data
  input wire logic            O_BVALID,
  input wire logic            I_BREADY,
  input wire logic            O_ARREADY,
  input wire logic            O_RVALID,
  input wire logic            I_RREADY,
  input wire logic [31:0]     O_RDATA,
  // Panel drive
  input wire logic            O_BIAS_LEVEL_OUT_LOW,
  input wire logic            O_BIAS_LEVEL_OUT_MID,
  input wire logic            O_BIAS_LEVEL_OUT_HIGH,
  input wire logic            O_BACKPLANE,
  input wire logic [NSEG-1:0] O_SEG
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fastest code 11 gives 64 base ticks; small slack for the synchroniser
  localparam int MIN_GAP = 64 * PRESCALE * CONV_CYC - 4;
  int   gap;
  logic armed;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Cycles since last backplane change; armed only after a full period
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      gap   <= 0;
      armed <= 1'b0;
    end else if ($changed(O_BACKPLANE)) begin
      gap   <= 0;
      armed <= O_BIAS_LEVEL_OUT_LOW && $past(O_BIAS_LEVEL_OUT_LOW);
    end else begin
      gap   <= gap + 1;
      armed <= armed && O_BIAS_LEVEL_OUT_LOW;
    end
  end
  a_bias_agree: assert property (O_BIAS_LEVEL_OUT_LOW == O_BIAS_LEVEL_OUT_MID
    && O_BIAS_LEVEL_OUT_MID == O_BIAS_LEVEL_OUT_HIGH) else $error("bias outputs differ");
  a_off_lines_low: assert property (!O_BIAS_LEVEL_OUT_HIGH |->
    !O_BACKPLANE && O_SEG == '0) else $error("line driven while off");
  a_seg_follow: assert property (O_BIAS_LEVEL_OUT_HIGH && $stable(O_BIAS_LEVEL_OUT_HIGH)
    && $changed(O_BACKPLANE) |-> O_SEG == ~$past(O_SEG)) else $error("segments off phase");
  a_bp_gap: assert property (armed && O_BIAS_LEVEL_OUT_LOW && $changed(O_BACKPLANE)
    |-> gap >= MIN_GAP) else $error("backplane changed too soon");
  a_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  a_ar_with_r: assert property (O_ARREADY |-> O_RVALID) else $error("arready alone");
  a_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write response dropped");
  a_b_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
endmodule // ldc_top_checker
bind ldc_top ldc_top_checker #(.NSEG(NSEG), .PRESCALE(PRESCALE), .CONV_CYC(5)) u_checker (
  .I_SYS_CLK, .I_RESET_N, .O_BVALID, .I_BREADY, .O_ARREADY, .O_RVALID, .I_RREADY,
  .O_RDATA, .O_BIAS_LEVEL_OUT_LOW, .O_BIAS_LEVEL_OUT_MID, .O_BIAS_LEVEL_OUT_HIGH,
  .O_BACKPLANE, .O_SEG);
`default_nettype wire

// ### sim/testbench.sv
// Testbench of the display drive control block: registers, scan rates, switch-off.
// Assumes ldc_cfg.svh on the include path and a 10 MHz converter clock.
`default_nettype none
`include "ldc_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRE = 4;
  localparam logic [15:0] A_CTRL = {`LDC_IDX_CTRL, 2'b00};
  localparam logic [15:0] A_SEGS = {`LDC_IDX_SEGS, 2'b00};
  localparam logic [15:0] A_STAT = {`LDC_IDX_STAT, 2'b00};
  localparam logic [15:0] A_BAD  = A_STAT + 16'h0004;
  logic I_SYS_CLK = 1'b0, I_RESET_N = 1'b0, I_CONV_CLK = 1'b0;
  logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0;
  logic [15:0] I_AWADDR = 16'h0000, I_ARADDR = 16'h0000;
  logic [31:0] I_WDATA = 32'h0000_0000;
  logic [3:0]  I_WSTRB = 4'h0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_BACKPLANE;
  logic O_BIAS_LEVEL_OUT_LOW, O_BIAS_LEVEL_OUT_MID, O_BIAS_LEVEL_OUT_HIGH, dark;
  logic [31:0] O_RDATA, per;
  logic [7:0]  O_SEG;
  ldc_pkg::ldc_resp_t O_BRESP, O_RRESP;
  int checks = 0, miscompares = 0;

  ldc_top #(.NSEG(8), .PRESCALE(PRE)) DUT (.I_SYS_CLK, .I_RESET_N, .I_CONV_CLK, .I_AWVALID,
    .O_AWREADY, .I_AWADDR, .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB, .O_BVALID, .I_BREADY,
    .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP,
    .O_BIAS_LEVEL_OUT_LOW, .O_BIAS_LEVEL_OUT_MID, .O_BIAS_LEVEL_OUT_HIGH, .O_BACKPLANE, .O_SEG);
  ldc_glass_model GLASS (.i_bias_low(O_BIAS_LEVEL_OUT_LOW), .i_bias_mid(O_BIAS_LEVEL_OUT_MID),
    .i_bias_high(O_BIAS_LEVEL_OUT_HIGH), .i_backplane(O_BACKPLANE), .i_seg(O_SEG),
    .o_dark(dark), .o_period(per));

  // Clocks; converter edges offset so they never meet a system edge
  initial begin
    forever #10 I_SYS_CLK = ~I_SYS_CLK;
  end
  initial begin
    #3;
    forever #50 I_CONV_CLK = ~I_CONV_CLK;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge I_SYS_CLK);
    I_AWVALID <= 1'b1;
    I_AWADDR  <= a;
    I_WVALID  <= 1'b1;
    I_WDATA   <= d;
    I_WSTRB   <= 4'hF;
    I_BREADY  <= 1'b1;
    do begin
      @(posedge I_SYS_CLK);
      if (O_AWREADY) I_AWVALID <= 1'b0;
      if (O_WREADY) I_WVALID <= 1'b0;
    end while (!O_BVALID);
    r = O_BRESP;
    I_BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge I_SYS_CLK);
    I_ARVALID <= 1'b1;
    I_ARADDR  <= a;
    I_RREADY  <= 1'b1;
    do begin
      @(posedge I_SYS_CLK);
      if (O_ARREADY) I_ARVALID <= 1'b0;
    end while (!O_RVALID);
    d = O_RDATA;
    r = O_RRESP;
    I_RREADY <= 1'b0;
  endtask

  // Reset state, read back, refused places
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    check(32'(dark), 32'h0000_0001);
    axi_rd(A_CTRL, d, r);
    check(d, `LDC_CTRL_RST);
    axi_wr(A_SEGS, 32'h0000_00A5, r);
    check({30'h0, r}, `LDC_RESP_OKAY);
    axi_wr(A_CTRL, 32'h0000_0025, r);
    check(32'(O_BIAS_LEVEL_OUT_MID), 32'h0000_0001);
    axi_rd(A_CTRL, d, r);
    check(d, 32'h0000_0025);
    axi_rd(A_SEGS, d, r);
    check(d, 32'h0000_00A5);
    // Phase bit masked: it depends on where the scan happens to be
    axi_rd(A_STAT, d, r);
    check(d & 32'hFFFF_FFF7, 32'h0000_0005);
    axi_rd(A_BAD, d, r);
    check(d, 32'h0000_0000);
    check({30'h0, r}, `LDC_RESP_SLVERR);
    axi_wr(A_STAT, 32'h0000_00FF, r);
    check({30'h0, r}, `LDC_RESP_SLVERR);
  endtask

  // Each selector code 11 down to 00; third change shows the new rate
  task automatic t_rates;
    logic [1:0] r;
    for (int s = 3; s >= 0; s--) begin
      axi_wr(A_CTRL, 32'h0000_0020 | s, r);
      repeat (3) @(O_BACKPLANE);
      @(posedge I_SYS_CLK);
      check(per, (512 >> s) * PRE * 100);
      check({24'h0, O_SEG}, {24'h0, {8{O_BACKPLANE}} ^ 8'hA5});
    end
  endtask

  // Clearing enable while moving the selector from 00 to 01 darkens the panel at once
  task automatic t_off;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(A_CTRL, 32'h0000_0005, r);
    check(32'(dark), 32'h0000_0001);
    axi_rd(A_CTRL, d, r);
    check(d, 32'h0000_0005);
    axi_wr(A_CTRL, 32'h0000_0025, r);
    check(32'(dark), 32'h0000_0000);
  endtask

  initial begin
    repeat (4) @(posedge I_SYS_CLK);
    I_RESET_N <= 1'b1;
    t_regs;
    t_rates;
    t_off;
    wrap_up;
  end

  // Watchdog: the scenarios need about two thirds of this span
  initial begin
    #1_600_000;
    miscompares++;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
